// [design/cbc_config.sv]
/*
  Cell balancing configuration registers with threshold decode and the
  qualification, active and settle interval timers. Assumes a plain
  register port whose strobes are single cycles and never overlap.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
//
// Contract
// - Exit offset is three bits spanning 30 mV to 100 mV in 10 mV steps.
// - Exit threshold equals start threshold minus exit offset.
// - Exit threshold below 10 mV is clamped to 10 mV.
// - Qualify interval bit: 0 gives 2 min, 1 gives 4 min.
// - Active interval field: 4 s, 32 s, 2 min, 4 min.
// - Settle field: 10 ms, 100 ms, 1 s, 2 s.
// - Pre-qualify threshold is 40 mV plus 10 mV per code step.
// - Pre-qualify code 1111 disables that stage and is the default.
// - Start threshold is 40 mV plus 10 mV per step, up to 190 mV.
// - Start threshold resets to code 0100, 80 mV.
// - Timing register at 28h resets to 2Ah.
// - Threshold register at 29h resets to F4h.
// - Register-reset bit restores defaults, restarts safety timer, then self-clears.
module cbc_config #(
  parameter int TICK_CYCLES = cbc_pkg::CBC_TICK_CYCLES
) (
  input wire logic i_clk_sys,                  // 40 MHz clock
  input wire logic i_nrst,                     // Sync reset, active low
  input wire logic [7:0] i_addr,               // Register address
  input wire logic [7:0] i_wdata,              // Write data
  input wire logic i_wr,                       // Write strobe
  input wire logic i_rd,                       // Read strobe
  output logic [7:0] o_rdata,                  // Read data, cycle after strobe
  input wire logic i_qual_start,               // Start qualify interval
  input wire logic i_active_start,             // Start active interval
  input wire logic i_settle_start,             // Start settle delay
  output logic o_qual_done,                    // Qualify interval elapsed
  output logic o_active_done,                  // Active interval elapsed
  output logic o_settle_done,                  // Settle delay elapsed
  output logic o_prequal_en,                   // Pre-qualify stage in use
  output logic [7:0] o_prequal_threshold_mv,   // Pre-qualify threshold
  output logic [7:0] o_start_threshold_mv,     // Start threshold
  output logic [7:0] o_exit_offset_mv,         // Exit offset
  output logic [7:0] o_exit_threshold_mv,      // Exit threshold
  output logic o_safety_timer_restart          // Safety timer restart pulse
);
  import cbc_pkg::*;

  function automatic logic [7:0] thr_mv(input logic [3:0] code);
    thr_mv = CBC_THR_BASE_MV + ({4'h0, code} * CBC_STEP_MV);
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  logic [7:0] timing;
  logic [7:0] thresh;
  logic reg_rst;
  logic [CBC_TICK_W-1:0] tick_cnt;
  logic tick;

  // Register writes; a pending register reset beats any write
  wire wr_rst = i_wr && hit(i_addr, CBC_ADDR_RST) && i_wdata[CBC_RST_BIT];
  wire wr_timing = i_wr && hit(i_addr, CBC_ADDR_TIMING);
  wire wr_thresh = i_wr && hit(i_addr, CBC_ADDR_THRESH);
  wire load_dflt = !i_nrst || reg_rst;
  wire next_reg_rst = i_nrst && !reg_rst && wr_rst;
  wire [7:0] next_timing = load_dflt ? CBC_TIMING_RST :
                           wr_timing ? i_wdata : timing;
  wire [7:0] next_thresh = load_dflt ? CBC_THRESH_RST :
                           wr_thresh ? i_wdata : thresh;

  // Field decode from the next register values keeps outputs aligned
  wire [2:0] ofs_code = next_timing[CBC_OFS_MSB:CBC_OFS_LSB];
  wire [3:0] pq_code = next_thresh[CBC_PQ_MSB:CBC_PQ_LSB];
  wire [3:0] st_code = next_thresh[CBC_ST_MSB:CBC_ST_LSB];
  wire [7:0] next_start_mv = thr_mv(st_code);
  wire [7:0] next_pq_mv = thr_mv(pq_code);
  wire next_pq_en = (pq_code != CBC_PQ_DISABLE);
  wire [7:0] next_ofs_mv = CBC_OFS_BASE_MV + ({5'h00, ofs_code} * CBC_STEP_MV);
  // Signed difference, since the offset may exceed the start value
  wire signed [8:0] exit_raw = $signed({1'b0, next_start_mv}) - $signed({1'b0, next_ofs_mv});
  wire exit_low = exit_raw < $signed({1'b0, CBC_EXIT_MIN_MV});
  wire [7:0] next_exit_mv = exit_low ? CBC_EXIT_MIN_MV : exit_raw[7:0];

  wire [7:0] rd_mux = hit(i_addr, CBC_ADDR_TIMING) ? timing :
                      hit(i_addr, CBC_ADDR_THRESH) ? thresh :
                      hit(i_addr, CBC_ADDR_RST) ? {reg_rst, 7'h00} : CBC_ZERO;
  wire [7:0] next_rdata = (i_rd && i_nrst) ? rd_mux : CBC_ZERO;

  always_ff @(posedge i_clk_sys) begin
    timing <= next_timing;
    thresh <= next_thresh;
    reg_rst <= next_reg_rst;
    o_safety_timer_restart <= i_nrst && reg_rst;
    o_rdata <= next_rdata;
  end

  always_ff @(posedge i_clk_sys) begin
    o_start_threshold_mv <= next_start_mv;
    o_prequal_threshold_mv <= next_pq_mv;
    o_prequal_en <= next_pq_en;
    o_exit_offset_mv <= next_ofs_mv;
    o_exit_threshold_mv <= next_exit_mv;
  end

  // Millisecond tick; restarted by register reset too
  wire tick_wrap = (tick_cnt == CBC_TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge i_clk_sys) begin
    if (load_dflt) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
      tick <= tick_wrap;
    end
  end

  // Interval selection
  wire qual_sel = timing[CBC_QUAL_BIT];
  wire [1:0] act_sel = timing[CBC_ACT_MSB:CBC_ACT_LSB];
  wire [1:0] set_sel = timing[CBC_SET_MSB:CBC_SET_LSB];
  wire cbc_ms_t qual_dur = qual_sel ? CBC_QUAL_4MIN_MS : CBC_QUAL_2MIN_MS;
  wire cbc_ms_t act_dur = act_sel[1] ? (act_sel[0] ? CBC_ACT_4MIN_MS : CBC_ACT_2MIN_MS) :
                                       (act_sel[0] ? CBC_ACT_32S_MS : CBC_ACT_4S_MS);
  wire cbc_ms_t set_dur = set_sel[1] ? (set_sel[0] ? CBC_SET_2S_MS : CBC_SET_1S_MS) :
                                       (set_sel[0] ? CBC_SET_100MS_MS : CBC_SET_10MS_MS);

  wire [CBC_NUM_TMR-1:0] tmr_start = {i_settle_start, i_active_start, i_qual_start};
  cbc_ms_t tmr_dur [CBC_NUM_TMR];
  logic [CBC_NUM_TMR-1:0] tmr_done;
  assign tmr_dur[CBC_TMR_QUAL] = qual_dur;
  assign tmr_dur[CBC_TMR_ACT] = act_dur;
  assign tmr_dur[CBC_TMR_SET] = set_dur;

  // Timers share the clear so a register reset aborts running intervals
  wire tmr_nrst = !load_dflt;
  cbc_tmr_if tmr_bus [CBC_NUM_TMR] ();
  genvar gi;
  generate
    for (gi = 0; gi < CBC_NUM_TMR; gi++) begin : g_tmr
      assign tmr_bus[gi].start = tmr_start[gi];
      assign tmr_bus[gi].dur = tmr_dur[gi];
      assign tmr_done[gi] = tmr_bus[gi].done;
      cbc_interval_timer u_tmr (
        .i_clk_sys(i_clk_sys),
        .i_nrst(tmr_nrst),
        .i_tick(tick),
        .bus(tmr_bus[gi])
      );
    end
  endgenerate

  assign o_qual_done = tmr_done[CBC_TMR_QUAL];
  assign o_active_done = tmr_done[CBC_TMR_ACT];
  assign o_settle_done = tmr_done[CBC_TMR_SET];

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  property p_exit_floor;
    o_exit_threshold_mv >= CBC_EXIT_MIN_MV;
  endproperty
  a_exit_floor: assert property (p_exit_floor) else $error("exit below floor");

  property p_exit_diff;
    (o_start_threshold_mv >= o_exit_offset_mv + CBC_EXIT_MIN_MV) |->
      (o_exit_threshold_mv == o_start_threshold_mv - o_exit_offset_mv);
  endproperty
  a_exit_diff: assert property (p_exit_diff) else $error("exit not start minus offset");

  property p_exit_clamp;
    (o_start_threshold_mv < o_exit_offset_mv + CBC_EXIT_MIN_MV) |->
      (o_exit_threshold_mv == CBC_EXIT_MIN_MV);
  endproperty
  a_exit_clamp: assert property (p_exit_clamp) else $error("exit not clamped");

  property p_offset_map;
    ##1 o_exit_offset_mv == CBC_OFS_BASE_MV + ({5'h00, timing[CBC_OFS_MSB:CBC_OFS_LSB]} * CBC_STEP_MV);
  endproperty
  a_offset_map: assert property (p_offset_map) else $error("offset decode wrong");

  property p_start_map;
    ##1 o_start_threshold_mv == thr_mv(thresh[CBC_ST_MSB:CBC_ST_LSB]);
  endproperty
  a_start_map: assert property (p_start_map) else $error("start decode wrong");

  property p_prequal_map;
    ##1 (o_prequal_en == (thresh[CBC_PQ_MSB:CBC_PQ_LSB] != CBC_PQ_DISABLE)) &&
        (o_prequal_threshold_mv == thr_mv(thresh[CBC_PQ_MSB:CBC_PQ_LSB]));
  endproperty
  a_prequal_map: assert property (p_prequal_map) else $error("pre-qualify decode wrong");

  property p_reset_vals;
    !$past(i_nrst) |-> (timing == CBC_TIMING_RST) && (thresh == CBC_THRESH_RST) && !o_prequal_en;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_wr_timing;
    (wr_timing && !reg_rst) |=> (timing == $past(i_wdata));
  endproperty
  a_wr_timing: assert property (p_wr_timing) else $error("timing write lost");

  property p_rd_timing;
    (i_rd && hit(i_addr, CBC_ADDR_TIMING)) |=> (o_rdata == $past(timing));
  endproperty
  a_rd_timing: assert property (p_rd_timing) else $error("timing readback wrong");

  sequence s_rst_req;
    wr_rst && !reg_rst;
  endsequence
  sequence s_rst_done;
    reg_rst ##1 (!reg_rst && o_safety_timer_restart && (timing == CBC_TIMING_RST) &&
                 (thresh == CBC_THRESH_RST));
  endsequence
  property p_soft_rst;
    s_rst_req |=> s_rst_done;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("register reset sequence wrong");

  property p_qual_dur;
    (i_qual_start && !load_dflt) |=> g_tmr[CBC_TMR_QUAL].u_tmr.cnt ==
      ($past(timing[CBC_QUAL_BIT]) ? CBC_QUAL_4MIN_MS : CBC_QUAL_2MIN_MS);
  endproperty
  a_qual_dur: assert property (p_qual_dur) else $error("qualify interval wrong");

  property p_set_short;
    (i_settle_start && (set_sel == 2'h0) && !load_dflt) |=> g_tmr[CBC_TMR_SET].u_tmr.cnt ==
      CBC_SET_10MS_MS;
  endproperty
  a_set_short: assert property (p_set_short) else $error("settle load wrong");

  property p_act_long;
    (i_active_start && (act_sel == 2'h3) && !load_dflt) |=> g_tmr[CBC_TMR_ACT].u_tmr.cnt ==
      CBC_ACT_4MIN_MS;
  endproperty
  a_act_long: assert property (p_act_long) else $error("active load wrong");

  property p_wr_thresh;
    (wr_thresh && !reg_rst) |=> (thresh == $past(i_wdata));
  endproperty
  a_wr_thresh: assert property (p_wr_thresh) else $error("threshold write lost");

  // Other writes and reads must leave both registers alone
  property p_timing_hold;
    (!wr_timing && !reg_rst) |=> $stable(timing);
  endproperty
  a_timing_hold: assert property (p_timing_hold) else $error("timing changed");

  property p_thresh_hold;
    (!wr_thresh && !reg_rst) |=> $stable(thresh);
  endproperty
  a_thresh_hold: assert property (p_thresh_hold) else $error("threshold changed");

  property p_rd_thresh;
    (i_rd && hit(i_addr, CBC_ADDR_THRESH)) |=> (o_rdata == $past(thresh));
  endproperty
  a_rd_thresh: assert property (p_rd_thresh) else $error("threshold readback wrong");

  property p_rd_rst_bit;
    (i_rd && hit(i_addr, CBC_ADDR_RST)) |=> (o_rdata == {$past(reg_rst), 7'h00});
  endproperty
  a_rd_rst_bit: assert property (p_rd_rst_bit) else $error("reset bit readback wrong");

  // Read data stands one cycle only, so a stale byte never lingers
  property p_rd_idle;
    !i_rd |=> (o_rdata == CBC_ZERO);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

  property p_rst_bit_clear;
    reg_rst |=> !reg_rst;
  endproperty
  a_rst_bit_clear: assert property (p_rst_bit_clear) else $error("reset bit stuck");

  property p_restart_once;
    o_safety_timer_restart |=> !o_safety_timer_restart;
  endproperty
  a_restart_once: assert property (p_restart_once) else $error("restart pulse too long");

  property p_restart_cause;
    o_safety_timer_restart |-> $past(reg_rst);
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart without reset");

  // Register reset must also abort every running interval
  property p_rst_abort;
    reg_rst |=> (tmr_done == '0) && !tmr_bus[CBC_TMR_QUAL].busy &&
      !tmr_bus[CBC_TMR_ACT].busy && !tmr_bus[CBC_TMR_SET].busy;
  endproperty
  a_rst_abort: assert property (p_rst_abort) else $error("interval not aborted");

  // Tick and counter wrap together, else intervals would drift
  property p_tick_wrap;
    tick |-> (tick_cnt == '0);
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("tick out of phase");
endmodule

// [design/cbc_interval_timer.sv]
/*
  One-shot interval timer counting millisecond ticks. Assumes a
  synchronous active-low clear and a one-cycle tick enable.
*/
`timescale 1ns/1ps
module cbc_interval_timer (
  input wire logic i_clk_sys, // System clock
  input wire logic i_nrst,    // Sync clear, active low
  input wire logic i_tick,    // 1 ms enable pulse
  cbc_tmr_if.tmr bus          // Start/done handshake
);
  import cbc_pkg::*;

  cbc_tstate_e state;
  cbc_ms_t cnt;
  logic done;

  wire last_tick = i_tick && (cnt == CBC_MS_ONE);

  // A fresh start restarts a running interval
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state <= CBC_T_IDLE;
      cnt <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        CBC_T_IDLE: begin
          if (bus.start) begin
            state <= CBC_T_RUN;
            cnt <= bus.dur;
          end
        end
        CBC_T_RUN: begin
          if (bus.start) begin
            cnt <= bus.dur;
          end else if (last_tick) begin
            state <= CBC_T_IDLE;
            done <= 1'b1;
          end else if (i_tick) begin
            cnt <= cnt - CBC_MS_ONE;
          end
        end
        default: begin
          state <= CBC_T_IDLE;
        end
      endcase
    end
  end

  assign bus.done = done;
  assign bus.busy = (state == CBC_T_RUN);

  property p_done_from_run;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(done) |-> $past(state == CBC_T_RUN) && (state == CBC_T_IDLE);
  endproperty
  a_done_from_run: assert property (p_done_from_run) else $error("done without run");

  property p_busy_after_start;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    bus.start |=> bus.busy;
  endproperty
  a_busy_after_start: assert property (p_busy_after_start) else $error("start not taken");
endmodule

// [design/cbc_pkg.sv]
/*
  Constants shared by the cell balancing configuration block: register
  offsets, reset values, field positions, threshold scaling and interval
  durations. Assumes a 40 MHz system clock.
*/
package cbc_pkg;
  localparam logic [7:0] CBC_ADDR_RST = 8'h25;
  localparam logic [7:0] CBC_ADDR_TIMING = 8'h28;
  localparam logic [7:0] CBC_ADDR_THRESH = 8'h29;
  localparam logic [7:0] CBC_TIMING_RST = 8'h2A;
  localparam logic [7:0] CBC_THRESH_RST = 8'hF4;
  localparam logic [7:0] CBC_ZERO = 8'h00;
  localparam int CBC_RST_BIT = 7;
  localparam int CBC_OFS_MSB = 7;
  localparam int CBC_OFS_LSB = 5;
  localparam int CBC_QUAL_BIT = 4;
  localparam int CBC_ACT_MSB = 3;
  localparam int CBC_ACT_LSB = 2;
  localparam int CBC_SET_MSB = 1;
  localparam int CBC_SET_LSB = 0;
  localparam int CBC_PQ_MSB = 7;
  localparam int CBC_PQ_LSB = 4;
  localparam int CBC_ST_MSB = 3;
  localparam int CBC_ST_LSB = 0;
  localparam logic [3:0] CBC_PQ_DISABLE = 4'hF;
  // Thresholds in mV
  localparam logic [7:0] CBC_THR_BASE_MV = 8'h28;
  localparam logic [7:0] CBC_STEP_MV = 8'h0A;
  localparam logic [7:0] CBC_OFS_BASE_MV = 8'h1E;
  localparam logic [7:0] CBC_EXIT_MIN_MV = 8'h0A;
  // Millisecond tick
  localparam int CBC_CLK_PERIOD_NS = 25;
  localparam int CBC_TICK_PERIOD_NS = 1000000;
  localparam int CBC_TICK_CYCLES = CBC_TICK_PERIOD_NS / CBC_CLK_PERIOD_NS;
  localparam int CBC_TICK_W = 16;
  // Durations counted in ms ticks
  localparam int CBC_MS_W = 18;
  typedef logic [CBC_MS_W-1:0] cbc_ms_t;
  localparam cbc_ms_t CBC_QUAL_2MIN_MS = 18'h1D4C0;
  localparam cbc_ms_t CBC_QUAL_4MIN_MS = 18'h3A980;
  localparam cbc_ms_t CBC_ACT_4S_MS = 18'h00FA0;
  localparam cbc_ms_t CBC_ACT_32S_MS = 18'h07D00;
  localparam cbc_ms_t CBC_ACT_2MIN_MS = 18'h1D4C0;
  localparam cbc_ms_t CBC_ACT_4MIN_MS = 18'h3A980;
  localparam cbc_ms_t CBC_SET_10MS_MS = 18'h0000A;
  localparam cbc_ms_t CBC_SET_100MS_MS = 18'h00064;
  localparam cbc_ms_t CBC_SET_1S_MS = 18'h003E8;
  localparam cbc_ms_t CBC_SET_2S_MS = 18'h007D0;
  localparam cbc_ms_t CBC_MS_ONE = 18'h00001;
  localparam int CBC_NUM_TMR = 3;
  localparam int CBC_TMR_QUAL = 0;
  localparam int CBC_TMR_ACT = 1;
  localparam int CBC_TMR_SET = 2;
  typedef enum logic [1:0] {
    CBC_T_IDLE = 2'b01,
    CBC_T_RUN = 2'b10
  } cbc_tstate_e;
endpackage

// [design/cbc_tmr_if.sv]
/*
  Start/done handshake between the configuration block and one interval
  timer. Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface cbc_tmr_if;
  logic start;
  cbc_pkg::cbc_ms_t dur;
  logic done;
  logic busy;
  modport ctrl (output start, output dur, input done, input busy);
  modport tmr (input start, input dur, output done, output busy);
endinterface

// [sim/testbench.sv]
/*
  Self-checking bench for the cell balancing configuration block:
  register defaults, threshold decode, register reset and interval timers.
  Assumes the design is built with a 2-cycle millisecond tick.
*/
`timescale 1ns/1ps
module testbench;
  import cbc_pkg::*;
  localparam int TK = 2;
  logic i_clk_sys;
  logic i_nrst;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [2:0] st;
  logic [7:0] o_rdata;
  wire [2:0] dn;
  logic o_prequal_en;
  logic [7:0] o_prequal_threshold_mv;
  logic [7:0] o_start_threshold_mv;
  logic [7:0] o_exit_offset_mv;
  logic [7:0] o_exit_threshold_mv;
  logic o_safety_timer_restart;
  int error_cnt;
  int num_checks;

  cbc_config #(.TICK_CYCLES(TK)) dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_qual_start(st[0]),
    .i_active_start(st[1]), .i_settle_start(st[2]), .o_qual_done(dn[0]),
    .o_active_done(dn[1]), .o_settle_done(dn[2]), .o_prequal_en(o_prequal_en),
    .o_prequal_threshold_mv(o_prequal_threshold_mv),
    .o_start_threshold_mv(o_start_threshold_mv), .o_exit_offset_mv(o_exit_offset_mv),
    .o_exit_threshold_mv(o_exit_threshold_mv),
    .o_safety_timer_restart(o_safety_timer_restart)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("unexpected at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Signals change right after an edge; the strobe is taken at the next one
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
    cyc(1'b0, 1'b0, a, d);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b0, a, 8'h00);
    #1;
    chk8(o_rdata, exp);
  endtask

  task automatic chk_defaults();
    rd(CBC_ADDR_TIMING, 8'h2A);
    rd(CBC_ADDR_THRESH, 8'hF4);
    chk8(o_start_threshold_mv, 8'h50);
    chk8(o_exit_offset_mv, 8'h28);
    chk8(o_exit_threshold_mv, 8'h28);
    chk8({7'h00, o_prequal_en}, 8'h00);
  endtask

  task automatic t_decode();
    int s;
    int o;
    int ex;
    for (s = 0; s < 16; s++) begin
      for (o = 0; o < 8; o++) begin
        wr(CBC_ADDR_THRESH, 8'(s * 17));
        wr(CBC_ADDR_TIMING, 8'(o * 32));
        // Low starts with big offsets break the software rule on purpose
        ex = (40 + 10 * s) - (30 + 10 * o);
        if (ex < 10) begin
          ex = 10;
        end
        chk8(o_start_threshold_mv, 8'(40 + 10 * s));
        chk8(o_exit_offset_mv, 8'(30 + 10 * o));
        chk8(o_exit_threshold_mv, 8'(ex));
        chk8({7'h00, o_prequal_en}, {7'h00, s != 15});
        if (s != 15) begin
          chk8(o_prequal_threshold_mv, 8'(40 + 10 * s));
        end
      end
      rd(CBC_ADDR_THRESH, 8'(s * 17));
    end
    $display("test decode done");
  endtask

  task automatic t_unmapped();
    wr(CBC_ADDR_TIMING, 8'h55);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    rd(CBC_ADDR_TIMING, 8'h55);
    $display("test unmapped done");
  endtask

  // Bit is visible only in the cycle after the write, hence the read right behind it
  task automatic t_reg_reset();
    wr(CBC_ADDR_THRESH, 8'h3C);
    cyc(1'b1, 1'b0, CBC_ADDR_RST, 8'h80);
    cyc(1'b0, 1'b1, CBC_ADDR_RST, 8'h00);
    cyc(1'b0, 1'b0, CBC_ADDR_RST, 8'h00);
    #1;
    chk8(o_rdata, 8'h80);
    chk8({7'h00, o_safety_timer_restart}, 8'h01);
    rd(CBC_ADDR_RST, 8'h00);
    chk_defaults();
    $display("test register reset done");
  endtask

  // Tick phase is unknown, so allow one tick of slack below and three cycles above
  task automatic run_tmr(input int idx, input int ms, input int lim);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    st[idx] <= 1'b1;
    @(posedge i_clk_sys);
    st[idx] <= 1'b0;
    #1;
    while (dn[idx] !== 1'b1 && n < lim) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    if (ms == 0) begin
      chk_rng(n, lim, lim);
    end else if (n >= lim) begin
      error_cnt++;
      $display("unexpected at %0t: timer never finished", $time);
      wrap_up();
    end else begin
      chk_rng(n, (ms - 1) * TK, ms * TK + 3);
    end
  endtask

  task automatic t_timers();
    int settle_ms[4] = '{10, 100, 1000, 2000};
    int act_ms[2] = '{4000, 32000};
    int c;
    for (c = 0; c < 4; c++) begin
      wr(CBC_ADDR_TIMING, 8'(c));
      run_tmr(2, settle_ms[c], 5000);
    end
    for (c = 0; c < 2; c++) begin
      wr(CBC_ADDR_TIMING, 8'(c * 4));
      run_tmr(1, act_ms[c], 70000);
    end
    wr(CBC_ADDR_TIMING, 8'h00);
    run_tmr(0, 0, 4000);
    $display("test timers done");
  endtask

  // Long intervals are only started; a register reset must then swallow every done
  task automatic t_abort();
    int n;
    wr(CBC_ADDR_TIMING, 8'h1C);
    run_tmr(0, 0, 200);
    run_tmr(1, 0, 200);
    @(posedge i_clk_sys);
    st[2] <= 1'b1;
    cyc(1'b1, 1'b0, CBC_ADDR_RST, 8'h80);
    st[2] <= 1'b0;
    cyc(1'b0, 1'b0, CBC_ADDR_RST, 8'h00);
    n = 0;
    #1;
    while (dn === 3'b000 && n < 100) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    chk_rng(n, 100, 100);
    $display("test abort done");
  endtask

  initial begin
    error_cnt = 0;
    num_checks = 0;
    i_nrst = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    st = 3'b000;
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    #1;
    chk_defaults();
    $display("test defaults done");
    t_decode();
    t_unmapped();
    t_reg_reset();
    t_timers();
    t_abort();
    wrap_up();
  end
endmodule
